// [drive_strength_pkg.sv]
package drive_strength_pkg;

  localparam int          APB_ADDR_W       = 12;
  localparam int          DATA_W           = 32;
  localparam int          REG_W            = 8;

  // register map (byte addresses)
  localparam logic [11:0] DRIVE_UPPER_ADDR = 12'h000;
  localparam logic [11:0] PAD_STATE_ADDR   = 12'h004;

  // field positions in drive_strength_upper_ports
  localparam int          E_LOW_BIT        = 0;
  localparam int          E_HIGH_BIT       = 1;
  localparam int          F_LOW_BIT        = 2;
  localparam int          F_HIGH_BIT       = 3;
  localparam int          G_LOW_BIT        = 4;
  localparam int          G_HIGH_BIT       = 5;
  localparam int          SPARE_LOW_BIT    = 6;
  localparam int          SPARE_HIGH_BIT   = 7;

  localparam logic [7:0]  DRIVE_RESET      = 8'h00;

  // drive levels
  localparam logic        LEVEL_MIN        = 1'b0;
  localparam logic        LEVEL_MAX        = 1'b1;

  // pin 1 of port e is not steered by this register
  localparam logic [7:0]  PORT_E_PIN_MASK  = 8'hfd;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [DATA_W-1:0]     pwdata;
  } apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [7:0] port_e;
    logic [7:0] port_f;
    logic [7:0] port_g;
  } pad_drive_t;

endpackage

// [nibble_drive_map.sv]
`timescale 1ns/10ps
module nibble_drive_map
  import drive_strength_pkg::*;
#(
  parameter logic [7:0] PIN_MASK = 8'hff
)
(
  input  wire logic       low_sel,
  input  wire logic       high_sel,
  output logic [7:0]      pin_level
);
  // one select bit per nibble; masked pins stay at minimum drive
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      if (PIN_MASK[i])
      begin : g_on
        assign pin_level[i] = (i < 4) ? low_sel : high_sel;
      end
      else
      begin : g_off
        assign pin_level[i] = LEVEL_MIN;
      end
    end
  endgenerate
endmodule

// [port_drive_strength_control.sv]
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module port_drive_strength_control
  import drive_strength_pkg::*;
#(
  parameter int ADDR_W = APB_ADDR_W
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire drive_strength_pkg::apb_req_t  apb_req,
  output drive_strength_pkg::apb_rsp_t  apb_rsp,
  output drive_strength_pkg::pad_drive_t pad_drive
);
  import drive_strength_pkg::*;

  initial
  begin
    if (ADDR_W != APB_ADDR_W)
      $error("ADDR_W must equal the package address width");
  end

  logic [REG_W-1:0] drive_r;
  logic [REG_W-1:0] drive_nxt;
  logic             access;
  logic             hit_drive;
  logic             hit_state;
  pad_drive_t       pad_nxt;
  logic [7:0]       e_lvl;
  logic [7:0]       f_lvl;
  logic [7:0]       g_lvl;

  assign access    = apb_req.psel && apb_req.penable;
  assign hit_drive = (apb_req.paddr == DRIVE_UPPER_ADDR);
  assign hit_state = (apb_req.paddr == PAD_STATE_ADDR);

  // all eight bits stored as written, the spare pair included;
  // the write lands only at the completing edge, so a long access phase writes once
  always_comb
  begin
    drive_nxt = drive_r;
    if (access && apb_rsp.pready && apb_req.pwrite && hit_drive)
      drive_nxt = apb_req.pwdata[REG_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      drive_r <= DRIVE_RESET;
    else
      drive_r <= drive_nxt;
  end

  // pad selects follow the register value being committed this edge
  nibble_drive_map #(.PIN_MASK(PORT_E_PIN_MASK)) u_map_e
  (
    .low_sel   (drive_nxt[E_LOW_BIT]),
    .high_sel  (drive_nxt[E_HIGH_BIT]),
    .pin_level (e_lvl)
  );

  nibble_drive_map #(.PIN_MASK(8'hff)) u_map_f
  (
    .low_sel   (drive_nxt[F_LOW_BIT]),
    .high_sel  (drive_nxt[F_HIGH_BIT]),
    .pin_level (f_lvl)
  );

  nibble_drive_map #(.PIN_MASK(8'hff)) u_map_g
  (
    .low_sel   (drive_nxt[G_LOW_BIT]),
    .high_sel  (drive_nxt[G_HIGH_BIT]),
    .pin_level (g_lvl)
  );

  always_comb
  begin
    pad_nxt.port_e = e_lvl;
    pad_nxt.port_f = f_lvl;
    pad_nxt.port_g = g_lvl;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pad_drive <= '0;
    else
      pad_drive <= pad_nxt;
  end

  // a zero wait state answer would need a comb output, so the answer is
  // registered and the access phase lasts two cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      apb_rsp <= '0;
    else if (access && !apb_rsp.pready)
    begin
      apb_rsp.pready  <= 1'b1;
      apb_rsp.pslverr <= !(hit_drive || hit_state);
      if (!apb_req.pwrite && hit_drive)
        apb_rsp.prdata <= {{(DATA_W-REG_W){1'b0}}, drive_r};
      else if (!apb_req.pwrite && hit_state)
        apb_rsp.prdata <= {8'h00, pad_drive.port_g, pad_drive.port_f, pad_drive.port_e};
      else
        apb_rsp.prdata <= '0;
    end
    else
    begin
      apb_rsp.pready  <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
      apb_rsp.prdata  <= '0;
    end
  end

  AST_SPARE_KEPT: assert property (@(posedge sys_clk) disable iff (rst)
    access && apb_rsp.pready && apb_req.pwrite && hit_drive |=>
      drive_r[SPARE_HIGH_BIT:SPARE_LOW_BIT] == $past(apb_req.pwdata[7:6]))
    else $error("spare bits not stored");

  AST_G_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    pad_drive.port_g[7:4] == {4{drive_r[G_HIGH_BIT]}})
    else $error("port g high nibble wrong");

  AST_G_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    pad_drive.port_g[3:0] == {4{drive_r[G_LOW_BIT]}})
    else $error("port g low nibble wrong");

  AST_F_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    pad_drive.port_f[7:4] == {4{drive_r[F_HIGH_BIT]}})
    else $error("port f high nibble wrong");

  AST_F_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    pad_drive.port_f[3:0] == {4{drive_r[F_LOW_BIT]}})
    else $error("port f low nibble wrong");

  AST_E_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    pad_drive.port_e[7:4] == {4{drive_r[E_HIGH_BIT]}})
    else $error("port e high nibble wrong");

  AST_E_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    pad_drive.port_e[3:0] == {drive_r[E_LOW_BIT], drive_r[E_LOW_BIT], LEVEL_MIN,
                              drive_r[E_LOW_BIT]})
    else $error("port e low group wrong");

  AST_MIN_LEVEL: assert property (@(posedge sys_clk) disable iff (rst)
    access && apb_rsp.pready && apb_req.pwrite && hit_drive && apb_req.pwdata[5:0] == 6'h00 |=>
      pad_drive == '0)
    else $error("cleared bits did not give minimum drive");

  AST_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
    access && !apb_rsp.pready |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("answer not one cycle after access");

  COV_WRITE_MAX: cover property (@(posedge sys_clk) disable iff (rst)
    access && apb_req.pwrite && hit_drive && apb_req.pwdata[7:0] == 8'hff);
  COV_READ_BACK: cover property (@(posedge sys_clk) disable iff (rst)
    access && !apb_req.pwrite && hit_drive && apb_rsp.pready);
  COV_BAD_ADDR: cover property (@(posedge sys_clk) disable iff (rst)
    apb_rsp.pslverr);

endmodule

// [tb.sv]
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      error_cnt++; \
      $display("unexpected at %0t: got %h, expected %h", $time, a, b); \
    end \
  end
module tb;
  import drive_strength_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  apb_req_t    apb_req = '0;
  apb_rsp_t    apb_rsp;
  pad_drive_t  pad_drive;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          comparisons = 0;
  logic [7:0]  v;

  port_drive_strength_control port_drive_strength_control_inst (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .apb_req   (apb_req),
    .apb_rsp   (apb_rsp),
    .pad_drive (pad_drive)
  );

  always #12.5 sys_clk = ~sys_clk;

  // pin 1 of port e stays at min whatever bit 0 says
  function automatic pad_drive_t exp_pad(input logic [7:0] r);
    exp_pad.port_e = {{4{r[1]}}, r[0], r[0], 1'b0, r[0]};
    exp_pad.port_f = {{4{r[3]}}, {4{r[2]}}};
    exp_pad.port_g = {{4{r[5]}}, {4{r[4]}}};
  endfunction

  task automatic end_of_test;
    $display("errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // outputs are read at the edge, before the design's own updates land
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_req.psel   <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr  <= a;
    apb_req.pwdata <= d;
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 50);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n >= 50)
      error_cnt++;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_of_test;
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, DRIVE_UPPER_ADDR, 32'h0);
    `CHK(rd, {24'h0, DRIVE_RESET})
    `CHK(pad_drive, exp_pad(8'h00))
    for (int i = 0; i < 8; i++)
    begin
      v = 8'h01 << i;
      apb(1'b1, DRIVE_UPPER_ADDR, {24'ha5a5a5, v});
      @(negedge sys_clk);
      `CHK(pad_drive, exp_pad(v))
      apb(1'b0, DRIVE_UPPER_ADDR, 32'h0);
      `CHK(rd, {24'h0, v})
      apb(1'b0, PAD_STATE_ADDR, 32'h0);
      `CHK(rd, {8'h00, exp_pad(v).port_g, exp_pad(v).port_f, exp_pad(v).port_e})
    end
    // back-to-back writes, then a read-only and an unmapped place
    apb(1'b1, DRIVE_UPPER_ADDR, 32'h0000_00ff);
    @(negedge sys_clk);
    `CHK(pad_drive, exp_pad(8'hff))
    apb(1'b1, PAD_STATE_ADDR, 32'h0);
    `CHK(err, 1'b0)
    apb(1'b1, 12'h008, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b0, DRIVE_UPPER_ADDR, 32'h0);
    `CHK(rd, 32'h0000_00ff)
    apb(1'b1, DRIVE_UPPER_ADDR, 32'h0000_00c0);
    @(negedge sys_clk);
    `CHK(pad_drive, exp_pad(8'hc0))
    // reset in mid-run clears the spare bits as well
    apb(1'b1, DRIVE_UPPER_ADDR, 32'h0000_00ea);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, DRIVE_UPPER_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(pad_drive, exp_pad(8'h00))
    end_of_test;
  end
endmodule
